// ==== common/scc_pkg.sv ====
// constants for the clock source select block
package scc_pkg;
   // register addresses
   localparam logic [15:0] ADDR_SUB_OSC_MODE = 16'hfff0;
   localparam logic [15:0] ADDR_CLK_SRC_SEL  = 16'hfff2;
   localparam logic [15:0] ADDR_PROC_CLK_CTL = 16'hfffb;
   // field positions
   localparam int SUB_STOP_BIT   = 0;
   localparam int FB_OFF_BIT     = 1;
   localparam int SUB_SEL_BIT    = 4;
   localparam int SRC_STAT_BIT   = 5;
   localparam int MAIN_DIV_BIT   = 1;
   localparam int MAIN_DIS_BIT   = 7;
   // reset values
   localparam logic [7:0] SUB_OSC_MODE_RST = 8'h00;
   localparam logic [7:0] CLK_SRC_SEL_RST  = 8'h00;
   localparam logic [7:0] PROC_CLK_CTL_RST = 8'h02;
   // prescaler: tick[i] pulses at main_clock_freq / 2^(i+1)
   localparam int PRESC_W  = 8;
   localparam int DIV4_IDX = 1;
endpackage : scc_pkg

// ==== common/scc_presc_if.sv ====
// link between the control logic and the main clock prescaler
`timescale 1ns/1ns
interface scc_presc_if;
   import scc_pkg::*;
   logic               run;
   logic [PRESC_W-1:0] tick;
   modport ctrl  (output run, input tick);
   modport presc (input run, output tick);
endinterface : scc_presc_if

// ==== hw/scc_prescaler.sv ====
// main clock prescaler producing divided enable pulses
`timescale 1ns/1ns
module scc_prescaler
   import scc_pkg::*;
(
   input  wire logic    clock_i,   // main clock
   input  wire logic    srst_i,    // sync reset, active high
   scc_presc_if.presc   presc      // run in, ticks out
);
   typedef struct packed {
      logic [PRESC_W-1:0] cnt;
   } scc_presc_s;

   scc_presc_s r;
   scc_presc_s next_r;

   always_comb begin
      next_r = r;
      if (presc.run) begin
         next_r.cnt = r.cnt + PRESC_W'(1);
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // each stage pulses once per 2^(i+1) main cycles, only while running [RULE_14]
   genvar i;
   generate
      for (i = 0; i < PRESC_W; i++) begin : g_tick
         assign presc.tick[i] = presc.run && (&r.cnt[i:0]);
      end
   endgenerate
endmodule : scc_prescaler

// ==== hw/scc_top.sv ====
// clock source selection, oscillator control and cpu clock enables
// Summary of operation
// [RULE_01] sub stop bit set halts sub oscillator
// [RULE_02] feedback bit set disconnects sub feedback resistor
// [RULE_03] reset clears sub oscillator mode register
// [RULE_04] reset clears clock source select register
// [RULE_05] select bit picks main or sub source
// [RULE_06] status bit read-only, shows active source
// [RULE_07] software writes zero to mode upper bits
// [RULE_08] software writes zero to select unused bits
// [RULE_09] reset picks slow main mode, oscillator stopped
// [RULE_10] three instruction times: fast, quarter, sub
// [RULE_11] stop only on main clock; halt always
// [RULE_12] disable bit stops main oscillator on sub
// [RULE_13] peripherals on main divider; timers on sub
// [RULE_14] prescaler divides main clock for enables
// [RULE_15] cut feedback only when sub unused
// [RULE_16] external clock drives input and its complement
// [RULE_17] cpu clock: fx, fx/4 or sub/2
// [RULE_18] software changes disable bit only on sub
// [RULE_19] status changes only once switch completes
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
module scc_top
   import scc_pkg::*;
(
   input  wire logic               clock_i,          // main clock, 10 MHz
   input  wire logic               srst_i,           // sync reset, active high
   input  wire logic [15:0]        addr_i,           // register address
   input  wire logic [7:0]         wdata_i,          // write data
   input  wire logic               we_i,             // write strobe
   input  wire logic               re_i,             // read strobe
   output logic      [7:0]         rdata_o,          // read data, cycle after strobe
   input  wire logic               sub_osc_in_i,     // sub oscillator pin, async
   input  wire logic               stop_req_i,       // cpu asks for stop mode
   input  wire logic               halt_req_i,       // cpu asks for halt mode
   input  wire logic               wake_i,           // standby release
   output logic                    main_osc_run_o,   // main oscillator enabled
   output logic                    sub_osc_stop_o,   // sub oscillator halted
   output logic                    sub_feedback_off_o, // sub feedback resistor removed
   output logic                    cpu_clk_en_o,     // one-cycle cpu clock enable
   output logic                    cpu_clock_source_status_o, // 1: cpu on sub clock
   output logic                    stop_mode_o,      // in stop mode
   output logic                    halt_mode_o,      // in halt mode
   output logic                    sub_tick_o,       // sub clock edge for timers
   output logic      [PRESC_W-1:0] periph_tick_o     // divided main clock enables
);
   typedef struct packed {
      logic       sub_stop;
      logic       fb_off;
      logic       sub_sel;
      logic       main_dis;
      logic       main_div;
      logic       cpu_clock_source_status;
      logic       stop_mode;
      logic       halt_mode;
      logic       main_run;
      logic       sync1;
      logic       sync2;
      logic       sub_prev;
      logic       sub_half;
      logic       cpu_tick;
      logic [7:0] rdata;
   } scc_state_s;

   scc_state_s r;
   scc_state_s next_r;

   scc_presc_if presc_bus ();

   scc_prescaler u_presc (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .presc   (presc_bus.presc)
   );

   function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
      hit = (a == base);
   endfunction : hit

   logic       sub_tick;
   logic       main_tick;
   logic       sub_cpu_tick;
   logic       switch_done;
   logic       standby;
   logic [7:0] rd_val;

   // sub edge seen only after two flops; oscillator gated by its stop bit
   assign sub_tick     = r.sync2 && !r.sub_prev && !r.sub_stop;  // [RULE_01]
   assign sub_cpu_tick = sub_tick && r.sub_half;                 // [RULE_17]
   // fast mode every cycle, slow mode every fourth
   assign main_tick    = r.main_run
                       && (r.main_div ? presc_bus.tick[DIV4_IDX] : 1'b1); // [RULE_17] [RULE_10]
   // a switch lands on an edge of the target clock
   assign switch_done  = (r.sub_sel != r.cpu_clock_source_status)
                       && (r.sub_sel ? sub_tick : main_tick);    // [RULE_19]
   assign standby      = r.stop_mode || r.halt_mode;

   assign presc_bus.run = r.main_run;                            // [RULE_14]

   always_comb begin
      rd_val = 8'h00;
      if (hit(addr_i, ADDR_SUB_OSC_MODE)) begin
         rd_val[SUB_STOP_BIT] = r.sub_stop;
         rd_val[FB_OFF_BIT]   = r.fb_off;
      end else if (hit(addr_i, ADDR_CLK_SRC_SEL)) begin
         rd_val[SUB_SEL_BIT]  = r.sub_sel;
         rd_val[SRC_STAT_BIT] = r.cpu_clock_source_status;
      end else if (hit(addr_i, ADDR_PROC_CLK_CTL)) begin
         rd_val[MAIN_DIS_BIT] = r.main_dis;
         rd_val[MAIN_DIV_BIT] = r.main_div;
      end
   end

   always_comb begin
      next_r = r;
      // sub pin synchroniser and edge tracking
      next_r.sync1    = sub_osc_in_i;
      next_r.sync2    = r.sync1;
      next_r.sub_prev = r.sync2;
      if (sub_tick) begin
         next_r.sub_half = !r.sub_half;                          // [RULE_17]
      end
      // register writes; unused bits are dropped
      if (we_i) begin
         if (hit(addr_i, ADDR_SUB_OSC_MODE)) begin
            next_r.sub_stop = wdata_i[SUB_STOP_BIT];             // [RULE_01]
            next_r.fb_off   = wdata_i[FB_OFF_BIT];               // [RULE_02]
         end else if (hit(addr_i, ADDR_CLK_SRC_SEL)) begin
            next_r.sub_sel  = wdata_i[SUB_SEL_BIT];              // [RULE_05] [RULE_06]
         end else if (hit(addr_i, ADDR_PROC_CLK_CTL)) begin
            next_r.main_dis = wdata_i[MAIN_DIS_BIT];
            next_r.main_div = wdata_i[MAIN_DIV_BIT];
         end
      end
      // active source follows select only on completion
      if (switch_done) begin
         next_r.cpu_clock_source_status = r.sub_sel;                                 // [RULE_19]
      end
      // standby entry and release
      if (wake_i) begin
         next_r.stop_mode = 1'b0;
         next_r.halt_mode = 1'b0;
      end else if (stop_req_i && !r.cpu_clock_source_status && !standby) begin
         next_r.stop_mode = 1'b1;                                // [RULE_11]
      end else if (halt_req_i && !standby) begin
         next_r.halt_mode = 1'b1;                                // [RULE_11]
      end
      // disable bit acts only while cpu runs from sub clock
      next_r.main_run = !(r.main_dis && r.cpu_clock_source_status) && !next_r.stop_mode; // [RULE_12] [RULE_18]
      // cpu enable from the active source, none in standby
      if (standby) begin
         next_r.cpu_tick = 1'b0;
      end else if (r.cpu_clock_source_status) begin
         next_r.cpu_tick = sub_cpu_tick;                         // [RULE_17]
      end else begin
         next_r.cpu_tick = main_tick;                            // [RULE_17]
      end
      next_r.rdata = re_i ? rd_val : 8'h00;
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         r          <= '0;
         r.sub_stop <= SUB_OSC_MODE_RST[SUB_STOP_BIT];           // [RULE_03]
         r.fb_off   <= SUB_OSC_MODE_RST[FB_OFF_BIT];             // [RULE_03]
         r.sub_sel  <= CLK_SRC_SEL_RST[SUB_SEL_BIT];             // [RULE_04]
         r.cpu_clock_source_status      <= CLK_SRC_SEL_RST[SRC_STAT_BIT];            // [RULE_04]
         r.main_dis <= PROC_CLK_CTL_RST[MAIN_DIS_BIT];           // [RULE_09]
         r.main_div <= PROC_CLK_CTL_RST[MAIN_DIV_BIT];           // [RULE_09]
      end else begin
         r <= next_r;
      end
   end

   assign rdata_o                 = r.rdata;
   assign main_osc_run_o          = r.main_run;                  // [RULE_09]
   assign sub_osc_stop_o          = r.sub_stop;
   assign sub_feedback_off_o      = r.fb_off;                    // [RULE_02]
   assign cpu_clk_en_o            = r.cpu_tick;
   assign cpu_clock_source_status_o = r.cpu_clock_source_status;                     // [RULE_06]
   assign stop_mode_o             = r.stop_mode;
   assign halt_mode_o             = r.halt_mode;
   // sub clock keeps timers alive through standby
   assign sub_tick_o              = sub_tick;                    // [RULE_13]
   assign periph_tick_o           = presc_bus.tick;              // [RULE_13]

   default clocking cb @(posedge clock_i); endclocking

   sub_mode_rst_a: assert property (@(posedge clock_i)  // [RULE_03]
      srst_i |=> !sub_osc_stop_o && !sub_feedback_off_o)
      else $error("sub oscillator mode not cleared by reset");

   src_sel_rst_a: assert property (@(posedge clock_i)  // [RULE_04]
      srst_i |=> !r.sub_sel && !cpu_clock_source_status_o)
      else $error("clock source select not cleared by reset");

   slow_main_rst_a: assert property (@(posedge clock_i)  // [RULE_09]
      srst_i |=> r.main_div && !r.main_dis && !main_osc_run_o && !cpu_clk_en_o)
      else $error("reset did not select slow main mode with oscillator stopped");

   sub_stop_wr_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_01]
      we_i && addr_i == ADDR_SUB_OSC_MODE |=> sub_osc_stop_o == $past(wdata_i[SUB_STOP_BIT])
         && !(sub_osc_stop_o && sub_tick_o))
      else $error("sub stop bit write not honoured");

   fb_off_wr_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_02]
      we_i && addr_i == ADDR_SUB_OSC_MODE |=> sub_feedback_off_o == $past(wdata_i[FB_OFF_BIT]))
      else $error("feedback resistor bit write not honoured");

   status_ro_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_06]
      we_i && addr_i == ADDR_CLK_SRC_SEL && wdata_i[SUB_SEL_BIT] == r.cpu_clock_source_status && r.sub_sel == r.cpu_clock_source_status
      |=> $stable(cpu_clock_source_status_o))
      else $error("status bit moved on a write");

   switch_land_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_19]
      $changed(cpu_clock_source_status_o) |-> $past(r.sub_sel != r.cpu_clock_source_status)
         && ($past(r.sub_sel) ? $past(sub_tick) : $past(main_tick)))
      else $error("status changed without a completed switch");

   quarter_rate_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_17]
      cpu_clk_en_o && $past(r.main_div) && !$past(r.cpu_clock_source_status)
      |=> (!cpu_clk_en_o || !$past(r.main_div) || $past(r.cpu_clock_source_status)) [*3])
      else $error("slow main cpu enable faster than one in four");

   stop_on_sub_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_11]
      r.cpu_clock_source_status && !stop_mode_o && stop_req_i |=> !stop_mode_o)
      else $error("stop mode entered while on sub clock");

   main_dis_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_12]
      r.main_dis && r.cpu_clock_source_status |=> !main_osc_run_o)
      else $error("main oscillator still running after disable on sub");

   periph_stop_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_13]
      !main_osc_run_o && $past(!main_osc_run_o)
      |-> periph_tick_o == '0 && !(cpu_clk_en_o && !r.cpu_clock_source_status))
      else $error("peripheral enables while main oscillator stopped");

   sel_write_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_05]
      we_i && addr_i == ADDR_CLK_SRC_SEL
      |=> r.sub_sel == $past(wdata_i[SUB_SEL_BIT]))
      else $error("source select write not honoured");

   sel_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_05]
      !(we_i && addr_i == ADDR_CLK_SRC_SEL)
      |=> $stable(r.sub_sel))
      else $error("source select moved without a write");

   sel_read_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_05]
      re_i && addr_i == ADDR_CLK_SRC_SEL
      |=> rdata_o[SUB_SEL_BIT] == $past(r.sub_sel))
      else $error("source select read back wrong");

   stat_read_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_06]
      re_i && addr_i == ADDR_CLK_SRC_SEL
      |=> rdata_o[SRC_STAT_BIT] == $past(cpu_clock_source_status_o))
      else $error("status bit read back wrong");

   mode_read_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_01]
      re_i && addr_i == ADDR_SUB_OSC_MODE
      |=> rdata_o[SUB_STOP_BIT] == $past(sub_osc_stop_o)
         && rdata_o[FB_OFF_BIT] == $past(sub_feedback_off_o))
      else $error("sub oscillator mode read back wrong");

   fb_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_02]
      !(we_i && addr_i == ADDR_SUB_OSC_MODE)
      |=> $stable(sub_feedback_off_o))
      else $error("feedback bit moved without a write");

   stop_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_01]
      !(we_i && addr_i == ADDR_SUB_OSC_MODE)
      |=> $stable(sub_osc_stop_o))
      else $error("sub stop bit moved without a write");

   sub_gate_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_01]
      sub_osc_stop_o
      |-> !sub_tick_o)
      else $error("sub edge while sub oscillator halted");

   sub_pulse_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_13]
      sub_tick_o
      |=> !sub_tick_o)
      else $error("sub edge pulse longer than one cycle");

   halt_on_sub_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_11]
      r.cpu_clock_source_status && !stop_mode_o && !halt_mode_o && halt_req_i && !wake_i
      |=> halt_mode_o)
      else $error("halt refused while on sub clock");

   stop_on_main_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_11]
      !r.cpu_clock_source_status && !stop_mode_o && !halt_mode_o && stop_req_i && !wake_i
      |=> stop_mode_o && !main_osc_run_o)
      else $error("stop refused while on main clock");

   wake_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_11]
      wake_i
      |=> !stop_mode_o && !halt_mode_o)
      else $error("standby not released by wake");

   standby_cpu_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_11]
      stop_mode_o || halt_mode_o
      |=> !cpu_clk_en_o)
      else $error("cpu enable during standby");

   fast_main_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_10]
      !r.cpu_clock_source_status && !r.main_div && main_osc_run_o && !stop_mode_o && !halt_mode_o
      |=> cpu_clk_en_o)
      else $error("fast main mode missed a cpu enable");

   sub_cpu_src_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_17]
      cpu_clk_en_o && $past(r.cpu_clock_source_status)
      |-> $past(sub_tick_o))
      else $error("sub mode cpu enable without a sub edge");

   main_cpu_src_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_17]
      cpu_clk_en_o && !$past(r.cpu_clock_source_status)
      |-> $past(main_osc_run_o))
      else $error("main mode cpu enable with main oscillator stopped");

   periph_main_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_13]
      (|periph_tick_o)
      |-> main_osc_run_o)
      else $error("peripheral enable without main oscillator");

   presc_div2_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_14]
      main_osc_run_o && $past(main_osc_run_o)
      |-> periph_tick_o[0] != $past(periph_tick_o[0]))
      else $error("first prescaler stage not halving the main clock");

   run_stop_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_11]
      main_osc_run_o
      |-> !stop_mode_o)
      else $error("main oscillator running in stop mode");

   main_keep_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_12]
      !r.main_dis && !stop_mode_o
      |=> main_osc_run_o || stop_mode_o)
      else $error("main oscillator stopped without disable or stop");

   stat_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_19]
      r.sub_sel == r.cpu_clock_source_status
      |=> $stable(cpu_clock_source_status_o))
      else $error("status moved with no switch pending");

   div_write_a: assert property (@(posedge clock_i) disable iff (srst_i)  // [RULE_10]
      we_i && addr_i == ADDR_PROC_CLK_CTL
      |=> r.main_div == $past(wdata_i[MAIN_DIV_BIT])
         && r.main_dis == $past(wdata_i[MAIN_DIS_BIT]))
      else $error("processor clock write not honoured");
endmodule : scc_top

// ==== tb/scc_sub_osc_model.sv ====
// sub oscillator source: square wave on the sub clock pin
`timescale 1ns/1ns
module scc_sub_osc_model #(
   parameter int HALF_NS = 730                  // half period, plain default
) (
   input  wire logic stop_i,                    // device halts the oscillator
   output logic      sub_osc_o                  // wave into the sub pin
);
   initial sub_osc_o = 1'b0;
   // a halted oscillator rests low, no edges
   always begin
      #(HALF_NS);
      if (stop_i) sub_osc_o = 1'b0;
      else sub_osc_o = ~sub_osc_o;
   end
endmodule : scc_sub_osc_model

// ==== tb/scc_top_bench.sv ====
// self-checking bench for the clock source select block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
   $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module scc_top_bench;
   import scc_pkg::*;
   logic               clock_i = 1'b0, srst_i = 1'b1, we_i = 1'b0, re_i = 1'b0;
   logic        [15:0] addr_i = 16'h0000;
   logic        [7:0]  wdata_i = 8'h00, rdata_o, v;
   logic               stop_req_i = 1'b0, halt_req_i = 1'b0, wake_i = 1'b0, sub_osc_in_i;
   logic               main_osc_run_o, sub_osc_stop_o, sub_feedback_off_o, cpu_clk_en_o;
   logic               cpu_clock_source_status_o, stop_mode_o, halt_mode_o, sub_tick_o;
   logic [PRESC_W-1:0] periph_tick_o;
   logic        [31:0] seed = 32'h4408;
   int                 bad_count = 0, compares = 0, n_cpu, n_p1, n_sub, n_per, k;
   bit                 seen;
   always #50 clock_i = ~clock_i;
   scc_top dut_u (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .sub_osc_in_i(sub_osc_in_i),
      .stop_req_i(stop_req_i), .halt_req_i(halt_req_i), .wake_i(wake_i),
      .main_osc_run_o(main_osc_run_o), .sub_osc_stop_o(sub_osc_stop_o),
      .sub_feedback_off_o(sub_feedback_off_o), .cpu_clk_en_o(cpu_clk_en_o),
      .cpu_clock_source_status_o(cpu_clock_source_status_o), .stop_mode_o(stop_mode_o),
      .halt_mode_o(halt_mode_o), .sub_tick_o(sub_tick_o), .periph_tick_o(periph_tick_o));
   scc_sub_osc_model sub_osc_u (.stop_i(sub_osc_stop_o), .sub_osc_o(sub_osc_in_i));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_i);
      we_i <= 1'b1; addr_i <= a; wdata_i <= d;
      @(posedge clock_i);
      we_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] ex);
      @(posedge clock_i);
      re_i <= 1'b1; addr_i <= a;
      @(posedge clock_i);
      re_i <= 1'b0;
      #1 `CHK("rdata", ex, rdata_o)
   endtask : rd
   // counts pulses over n settled cycles
   task automatic cnt(input int n);
      n_cpu = 0; n_p1 = 0; n_sub = 0; n_per = 0;
      repeat (2) @(posedge clock_i);
      repeat (n) begin
         @(negedge clock_i);
         n_cpu += int'(cpu_clk_en_o === 1'b1);
         n_p1 += int'(periph_tick_o[1] === 1'b1);
         n_sub += int'(sub_tick_o === 1'b1);
         n_per += int'(|periph_tick_o === 1'b1);
      end
   endtask : cnt
   task automatic sb(input logic s, input logic h, input logic w);
      @(posedge clock_i);
      stop_req_i <= s; halt_req_i <= h; wake_i <= w;
      @(posedge clock_i);
      stop_req_i <= 1'b0; halt_req_i <= 1'b0; wake_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
   endtask : sb
   // bounded wait for the status bit, noting sub edges meanwhile
   task automatic wait_stat(input logic ex);
      seen = (sub_tick_o === 1'b1);
      for (k = 0; k < 200 && cpu_clock_source_status_o !== ex; k++) begin
         @(negedge clock_i);
         if (sub_tick_o === 1'b1) seen = 1'b1;
      end
      `CHK("switch", ex, cpu_clock_source_status_o)
      if (k >= 200) conclude();
   endtask : wait_stat
   initial begin
      repeat (50000) @(posedge clock_i);
      bad_count++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clock_i);
      srst_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      @(negedge clock_i);
      `CHK("main_run", 1'b1, main_osc_run_o)
      rd(ADDR_SUB_OSC_MODE, 8'h00);
      rd(ADDR_CLK_SRC_SEL, 8'h00);
      rd(ADDR_PROC_CLK_CTL, 8'h02);
      rd(16'hfff1, 8'h00);
      cnt(40);
      `CHK("cpu_quarter", 10, n_cpu)
      `CHK("presc_div4", 10, n_p1)
      wr(ADDR_PROC_CLK_CTL, 8'h00);
      cnt(40);
      `CHK("cpu_full", 40, n_cpu)
      seed = xs(seed);
      for (int i = 0; i < 4; i++) begin
         v = {6'h00, 2'(i) ^ seed[1:0]};
         wr(ADDR_SUB_OSC_MODE, v);
         @(negedge clock_i);
         `CHK("sub_stop", v[0], sub_osc_stop_o)
         `CHK("fb_off", v[1], sub_feedback_off_o)
         rd(ADDR_SUB_OSC_MODE, v);
      end
      wr(ADDR_SUB_OSC_MODE, 8'h00);
      sb(1'b1, 1'b0, 1'b0);
      `CHK("stop_main", 1'b1, stop_mode_o)
      `CHK("osc_in_stop", 1'b0, main_osc_run_o)
      sb(1'b0, 1'b0, 1'b1);
      sb(1'b0, 1'b1, 1'b0);
      `CHK("halt_main", 1'b1, halt_mode_o)
      cnt(20);
      `CHK("cpu_gated", 0, n_cpu)
      sb(1'b0, 1'b0, 1'b1);
      wr(ADDR_CLK_SRC_SEL, 8'h20);
      rd(ADDR_CLK_SRC_SEL, 8'h00);
      wr(ADDR_CLK_SRC_SEL, 8'h10);
      @(negedge clock_i);
      `CHK("stat_early", 1'b0, cpu_clock_source_status_o)
      wait_stat(1'b1);
      `CHK("tick_first", 1'b1, seen)
      rd(ADDR_CLK_SRC_SEL, 8'h30);
      sb(1'b1, 1'b0, 1'b0);
      `CHK("stop_sub", 1'b0, stop_mode_o)
      sb(1'b0, 1'b1, 1'b0);
      `CHK("halt_sub", 1'b1, halt_mode_o)
      sb(1'b0, 1'b0, 1'b1);
      wr(ADDR_PROC_CLK_CTL, 8'h80);
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      `CHK("main_off", 1'b0, main_osc_run_o)
      cnt(300);
      `CHK("periph_off", 0, n_per)
      `CHK("timer_tick", 1'b1, n_sub > 10)
      `CHK("cpu_sub", 1'b1, n_cpu >= n_sub / 2 - 1 && n_cpu <= n_sub / 2 + 1)
      wr(ADDR_SUB_OSC_MODE, 8'h01);
      cnt(100);
      `CHK("sub_halted", 0, n_sub)
      wr(ADDR_SUB_OSC_MODE, 8'h00);
      wr(ADDR_PROC_CLK_CTL, 8'h00);
      repeat (4) @(posedge clock_i);
      wr(ADDR_CLK_SRC_SEL, 8'h00);
      wait_stat(1'b0);
      rd(ADDR_CLK_SRC_SEL, 8'h00);
      conclude();
   end
endmodule : scc_top_bench
